/* File: inc/iel_params.svh */
// Purpose: offsets, field positions and reset values of the error route and log bank
// Assumes: 8-bit register address, 32-bit register data
// Notes:   definitions only
`ifndef IEL_PARAMS_SVH
`define IEL_PARAMS_SVH

// register offsets
`define IEL_OFF_MASK2    8'hd2
`define IEL_OFF_MCMASK   8'hd3
`define IEL_OFF_LOG0     8'hd8
`define IEL_OFF_LOG1     8'hdc
`define IEL_OFF_LOG2     8'he0
`define IEL_OFF_LOG3     8'he4
`define IEL_OFF_LOGCTL   8'hec
`define IEL_OFF_ISTAT    8'hf0
`define IEL_OFF_IMASK    8'hf4

// error type bit positions, shared by both route masks
`define IEL_BIT_UNCORR   7
`define IEL_BIT_COHER    6
`define IEL_BIT_MTAG     5
`define IEL_BIT_PSN_OUT  4
`define IEL_BIT_RESILV   3
`define IEL_BIT_PSN_PASS 2
`define IEL_BIT_ADDRMAP  1
`define IEL_BIT_CORR     0

// log control fields
`define IEL_LC_VALID     31
`define IEL_LC_NREC      15
`define IEL_LC_REC       14
`define IEL_LC_CAPTURE_A     12

// interrupt status fields
`define IEL_IS_TAKEN     0
`define IEL_IS_MISSED    1

// reset values and writable bits
`define IEL_MASK_RST     8'h00
`define IEL_LOG_RST      32'h0000_0000
`define IEL_LOG1_WMASK   32'hffef_7fff
`define IEL_TAG_LOW      96

`endif

/* File: inc/iel_pkg.sv */
// Purpose: shared types of the error route and log bank
// Assumes: nothing
// Notes:   numeric constants live in iel_params.svh
package iel_pkg;
  typedef logic [7:0] iel_mask_t;
  typedef enum logic [1:0] {
    IEL_SEV_NONE = 2'b00,
    IEL_SEV_REC  = 2'b01,
    IEL_SEV_NREC = 2'b10
  } iel_sev_e;
endpackage : iel_pkg

/* File: testbench/iel_fault_src.sv */
// Purpose: far side model, raises internal error flags and presents transaction details
// Assumes: requests from the bench change right after a rising edge
// Notes:   details are a pure function of the seed so the bench can predict every log field
`timescale 1ns/1ps
`default_nettype none

module iel_fault_src (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  flag_req,
  input  wire logic [31:0] seed,
  output var  logic [7:0]  err_flags,
  output var  logic [39:2] txn_addr,
  output var  logic        txn_write,
  output var  logic        txn_dram,
  output var  logic [6:0]  dir_id,
  output var  logic [3:0]  wb_cnt,
  output var  logic        non_posted,
  output var  logic        byp,
  output var  logic        line,
  output var  logic [99:0] tag
);
  logic [31:0] s;

  // registered so flags and details move only just after an edge, as real logic would
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_flags <= 8'h00;
      s         <= 32'h0000_0000;
    end else begin
      err_flags <= flag_req;
      s         <= seed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign txn_addr  = {s[7:0], s[31:2]};
  assign txn_write = s[1];
  assign txn_dram  = s[0];
  assign dir_id    = s[14:8];
  assign wb_cnt    = s[19:16];
  assign byp       = s[21];
  assign non_posted = s[22];
  assign line      = s[23];
  // inverted copies so a swapped tag word shows up
  assign tag       = {s[31:28], ~s, s, ~s};
endmodule : iel_fault_src

`default_nettype wire

/* File: testbench/tb_iel_error_route_log.sv */
// Purpose: self-checking bench of the error route and log bank
// Assumes: 50 MHz clock, bus driven by non-blocking assignment at the rising edge
// Notes:   one watchdog cuts a hang short
`timescale 1ns/1ps
`default_nettype none
`include "iel_params.svh"

module tb_iel_error_route_log;
  logic        clk, sys_rst, reg_wr, reg_rd, txn_write, txn_dram, non_posted, byp, line;
  logic        error_out2, machine_check_output, irq;
  logic [7:0]  reg_addr, flag_req, err_flags, b;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic [3:0]  trig, wb_cnt;
  logic [39:2] txn_addr;
  logic [6:0]  dir_id;
  logic [99:0] tag;
  int          n_mismatch, comparisons;

  iel_error_route_log #(.TAG_W(100)) iel_error_route_log_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_flags(err_flags),
    .first_fault_nonfatal(trig[0]), .first_fault_fatal(trig[1]),
    .memory_link_first_fault(trig[2]), .memory_link_next_fault(trig[3]),
    .txn_addr(txn_addr), .txn_write(txn_write), .txn_dram(txn_dram),
    .directory_entry_id(dir_id), .pending_writeback_count(wb_cnt),
    .non_posted_flag(non_posted),
    .bypass_unused_flag(byp), .line_status_flag(line), .request_tag_snapshot(tag),
    .error_out2(error_out2), .machine_check_output(machine_check_output), .irq(irq));

  iel_fault_src iel_fault_src_i (
    .clk(clk), .sys_rst(sys_rst), .flag_req(flag_req), .seed(seed), .err_flags(err_flags),
    .txn_addr(txn_addr), .txn_write(txn_write), .txn_dram(txn_dram), .dir_id(dir_id),
    .wb_cnt(wb_cnt), .non_posted(non_posted), .byp(byp), .line(line), .tag(tag));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // generous: the sequence needs well under 1000 cycles
  initial begin
    #100us;
    n_mismatch++;
    complete_run();
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk32(reg_rdata, exp, "read data");
  endtask : rd

  task automatic pulse(input logic [3:0] t, input int n);
    @(posedge clk);
    trig <= t;
    repeat (n) @(posedge clk);
    trig <= 4'h0;
  endtask : pulse

  function automatic logic [31:0] lg1(input logic [31:0] s);
    lg1 = {4'h0, s[31:28], s[23:21], 1'b0, s[19:16], 1'b0, s[14:8], s[7:0]};
  endfunction : lg1

  task automatic chk_logs(input logic [31:0] s);
    rd(`IEL_OFF_LOG0, s);
    rd(`IEL_OFF_LOG1, lg1(s));
    rd(`IEL_OFF_LOG2, ~s);
    rd(`IEL_OFF_LOG3, s);
  endtask : chk_logs

  task automatic reset_checks;
    rd(`IEL_OFF_MASK2, 32'h0000_0000);
    rd(`IEL_OFF_MCMASK, 32'h0000_0000);
    rd(`IEL_OFF_LOG0, 32'h0000_0000);
    rd(`IEL_OFF_LOG1, 32'h0000_0000);
    rd(`IEL_OFF_LOG2, 32'h0000_0000);
    rd(`IEL_OFF_LOG3, 32'h0000_0000);
    rd(`IEL_OFF_LOGCTL, 32'h0000_0000);
    chk1(error_out2, 1'b0, "error out 2 after reset");
  endtask : reset_checks

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, flag_req, seed, trig} = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    reset_checks();
    // flags with clear masks must stay off both outputs
    @(posedge clk);
    flag_req <= 8'hff;
    repeat (3) @(posedge clk);
    #1;
    chk1(error_out2, 1'b0, "error out 2 masked");
    chk1(machine_check_output, 1'b0, "machine check masked");
    wr(`IEL_OFF_MASK2, 32'h0000_0001);
    #1;
    chk1(error_out2, 1'b0, "mask write too early");
    @(posedge clk);
    #1;
    chk1(error_out2, 1'b1, "mask write one cycle on");
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      // flags drop first so the previous pattern cannot leak through the new mask
      @(posedge clk);
      flag_req <= 8'h00;
      wr(`IEL_OFF_MASK2, {24'h0, b});
      wr(`IEL_OFF_MCMASK, {24'h0, ~b});
      @(posedge clk);
      flag_req <= b;
      @(posedge clk);
      #1;
      chk1(error_out2, 1'b0, "flag arrives early");
      @(posedge clk);
      #1;
      chk1(error_out2, 1'b1, "error out 2 routed");
      chk1(machine_check_output, 1'b0, "machine check unrouted");
      @(posedge clk);
      flag_req <= ~b;
      repeat (2) @(posedge clk);
      #1;
      chk1(error_out2, 1'b0, "error out 2 unrouted");
      chk1(machine_check_output, 1'b1, "machine check routed");
    end
    // a cleared mask still routes for one cycle, then stops
    wr(`IEL_OFF_MASK2, 32'h0000_00ff);
    wr(`IEL_OFF_MASK2, 32'h0000_0000);
    #1;
    chk1(error_out2, 1'b1, "old mask still routes");
    @(posedge clk);
    #1;
    chk1(error_out2, 1'b0, "cleared mask stops routing");
    @(posedge clk);
    flag_req <= 8'h00;
    // recoverable capture, second back-to-back trigger is missed
    seed <= 32'hc3a5_96f1;
    wr(`IEL_OFF_IMASK, 32'h0000_0003);
    wr(`IEL_OFF_LOGCTL, 32'h0000_4000);
    pulse(4'h1, 2);
    chk_logs(32'hc3a5_96f1);
    rd(`IEL_OFF_LOGCTL, 32'h8000_0000);
    rd(`IEL_OFF_ISTAT, 32'h0000_0013);
    chk1(irq, 1'b1, "irq after capture");
    @(posedge clk);
    #1;
    chk32(reg_rdata, 32'h0000_0000, "read data stands one cycle");
    wr(`IEL_OFF_ISTAT, 32'h0000_0003);
    rd(`IEL_OFF_ISTAT, 32'h0000_0010);
    chk1(irq, 1'b0, "irq after clear");
    // fatal capture with re-arm keeps its enable
    @(posedge clk);
    seed <= 32'h5a3c_e10e;
    wr(`IEL_OFF_LOGCTL, 32'h0000_9000);
    pulse(4'h2, 1);
    chk_logs(32'h5a3c_e10e);
    rd(`IEL_OFF_LOGCTL, 32'h8000_9000);
    rd(`IEL_OFF_ISTAT, 32'h0000_0021);
    // memory link faults load the address log only
    @(posedge clk);
    seed <= 32'h1234_5678;
    wr(`IEL_OFF_LOGCTL, 32'h0000_5000);
    pulse(4'h4, 1);
    rd(`IEL_OFF_LOG0, 32'h1234_5678);
    rd(`IEL_OFF_LOG1, lg1(32'h5a3c_e10e));
    @(posedge clk);
    seed <= 32'h8765_4321;
    pulse(4'h8, 1);
    rd(`IEL_OFF_LOG0, 32'h8765_4321);
    // software access, reserved bits and an unmapped offset
    wr(`IEL_OFF_LOG0, 32'h0f0f_a55a);
    rd(`IEL_OFF_LOG0, 32'h0f0f_a55a);
    wr(`IEL_OFF_LOG1, 32'hffff_ffff);
    rd(`IEL_OFF_LOG1, 32'hffef_7fff);
    wr(`IEL_OFF_LOG3, 32'h3c3c_0ff0);
    rd(`IEL_OFF_LOG3, 32'h3c3c_0ff0);
    wr(`IEL_OFF_MCMASK, 32'hffff_ffa5);
    rd(`IEL_OFF_MCMASK, 32'h0000_00a5);
    wr(8'hd4, 32'hffff_ffff);
    rd(8'hd4, 32'h0000_0000);
    // second reset in mid-run clears every sticky field
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    reset_checks();
    complete_run();
  end
endmodule : tb_iel_error_route_log

`default_nettype wire

/* File: verilog/iel_err_route.sv */
// Purpose: one error output from flags gated by a route mask
// Assumes: flags and mask are on clk
// Notes:   output registered so it is glitch free toward the pins
`timescale 1ns/1ps
`default_nettype none

module iel_err_route #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] flags,
  input  wire logic [W-1:0] mask,
  output var  logic         err_out
);

  wire logic hit = |(flags & mask);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_out <= 1'b0;
    end else begin
      err_out <= hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_route_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (flags & mask) == '0 |=> !err_out)
    else $error("error output raised with nothing routed");

endmodule : iel_err_route

`default_nettype wire

/* File: verilog/iel_error_route_log.sv */
// Purpose: internal error routing to error output 2 and machine check, with fault capture
// Assumes: trigger inputs are one-cycle pulses on clk; flags are levels on clk
// Notes:   read data stand only in the cycle after the read strobe
//
// Summary of operation
// - error output 2 rises when a flag is set and its bit in the error-2 route mask is set.
// - the machine check output rises when a flag is set and its machine-check mask bit is set.
// - both masks share one layout: 7 uncorr, 6 coher, 5 multi-tag, 4..0 poison/silver/map/ecc.
// - all mask bits are writable, sticky and reset to zero so nothing routes at power-up.
// - address log captures on a first fatal or non-fatal fault and on memory link faults.
// - address log holds address 31:2 in place, bit 1 for a write, bit 0 for a DRAM target.
// - attribute log holds address 39:32, entry id 14:8, writebacks 19:16; bits 15, 20 read 0.
// - attribute log bit 22 non-posted, bit 21 bypass unused, bit 23 line status.
// - tag snapshot bits 31:0 and 63:32 go to two logs; bits 96 and up go to attribute 31:24.
// - all capture fields are sticky, software writable and reset to zero.
// - capture only while its severity enable is set; without re-arm that enable then clears.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "iel_params.svh"

module iel_error_route_log #(
  parameter int TAG_W = 100
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  logic [31:0]      reg_rdata,
  input  wire logic [7:0]       err_flags,
  input  wire logic             first_fault_nonfatal,
  input  wire logic             first_fault_fatal,
  input  wire logic             memory_link_first_fault,
  input  wire logic             memory_link_next_fault,
  input  wire logic [39:2]      txn_addr,
  input  wire logic             txn_write,
  input  wire logic             txn_dram,
  input  wire logic [6:0]       directory_entry_id,
  input  wire logic [3:0]       pending_writeback_count,
  input  wire logic             non_posted_flag,
  input  wire logic             bypass_unused_flag,
  input  wire logic             line_status_flag,
  input  wire logic [TAG_W-1:0] request_tag_snapshot,
  output var  logic             error_out2,
  output var  logic             machine_check_output,
  output var  logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire logic wr_mask2  = reg_wr & (reg_addr == `IEL_OFF_MASK2);
  wire logic wr_mcmask = reg_wr & (reg_addr == `IEL_OFF_MCMASK);
  wire logic wr_log0   = reg_wr & (reg_addr == `IEL_OFF_LOG0);
  wire logic wr_log1   = reg_wr & (reg_addr == `IEL_OFF_LOG1);
  wire logic wr_log2   = reg_wr & (reg_addr == `IEL_OFF_LOG2);
  wire logic wr_log3   = reg_wr & (reg_addr == `IEL_OFF_LOG3);
  wire logic wr_logctl = reg_wr & (reg_addr == `IEL_OFF_LOGCTL);
  wire logic wr_istat  = reg_wr & (reg_addr == `IEL_OFF_ISTAT);
  wire logic wr_imask  = reg_wr & (reg_addr == `IEL_OFF_IMASK);

  //////////////////////////////////////////////////////////////////////////////
  // route masks and error outputs

  iel_pkg::iel_mask_t mask2;
  iel_pkg::iel_mask_t mcmask;

  // one layout for both masks, every bit writable
  iel_sticky_reg #(.W(8)) u_mask2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sw_we   (wr_mask2),
    .sw_d    (reg_wdata[7:0]),
    .hw_we   (1'b0),
    .hw_d    (`IEL_MASK_RST),
    .q       (mask2)
  );

  iel_sticky_reg #(.W(8)) u_mcmask (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sw_we   (wr_mcmask),
    .sw_d    (reg_wdata[7:0]),
    .hw_we   (1'b0),
    .hw_d    (`IEL_MASK_RST),
    .q       (mcmask)
  );

  // overlapping masks are not policed: a doubly routed error fires both outputs
  iel_err_route #(.W(8)) u_route2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .flags   (err_flags),
    .mask    (mask2),
    .err_out (error_out2)
  );

  iel_err_route #(.W(8)) u_routemc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .flags   (err_flags),
    .mask    (mcmask),
    .err_out (machine_check_output)
  );

  //////////////////////////////////////////////////////////////////////////////
  // capture triggers

  logic rec_en;
  logic nrec_en;
  logic capture_a;
  logic valid;

  wire logic trig_rec  = first_fault_nonfatal | memory_link_first_fault
                         | memory_link_next_fault;
  wire logic take_rec  = trig_rec & rec_en;
  wire logic take_nrec = first_fault_fatal & nrec_en;
  wire logic take_any  = take_rec | take_nrec;
  // memory link faults only fill the address log
  wire logic take_full = take_nrec | (first_fault_nonfatal & rec_en);
  wire logic missed    = (trig_rec & ~rec_en) | (first_fault_fatal & ~nrec_en);

  iel_pkg::iel_sev_e cur_sev;
  assign cur_sev = take_nrec ? iel_pkg::IEL_SEV_NREC :
                   (take_rec ? iel_pkg::IEL_SEV_REC : iel_pkg::IEL_SEV_NONE);

  //////////////////////////////////////////////////////////////////////////////
  // capture data

  wire logic [7:0]  tag_top  = 8'(request_tag_snapshot[TAG_W-1:`IEL_TAG_LOW]);
  wire logic [31:0] cap_log0 = {txn_addr[31:6], txn_addr[5:2],
                                txn_write, txn_dram};
  wire logic [31:0] cap_log1 = {tag_top, line_status_flag, non_posted_flag,
                                bypass_unused_flag, 1'b0, pending_writeback_count,
                                1'b0, directory_entry_id, txn_addr[39:32]};
  wire logic [31:0] sw_log1  = reg_wdata & `IEL_LOG1_WMASK;

  logic [31:0] log0;
  logic [31:0] log1;
  logic [31:0] log2;
  logic [31:0] log3;

  iel_sticky_reg #(.W(32)) u_log0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sw_we   (wr_log0),
    .sw_d    (reg_wdata),
    .hw_we   (take_any),
    .hw_d    (cap_log0),
    .q       (log0)
  );

  iel_sticky_reg #(.W(32)) u_log1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sw_we   (wr_log1),
    .sw_d    (sw_log1),
    .hw_we   (take_full),
    .hw_d    (cap_log1),
    .q       (log1)
  );

  iel_sticky_reg #(.W(32)) u_log2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sw_we   (wr_log2),
    .sw_d    (reg_wdata),
    .hw_we   (take_full),
    .hw_d    (request_tag_snapshot[31:0]),
    .q       (log2)
  );

  iel_sticky_reg #(.W(32)) u_log3 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sw_we   (wr_log3),
    .sw_d    (reg_wdata),
    .hw_we   (take_full),
    .hw_d    (request_tag_snapshot[63:32]),
    .q       (log3)
  );

  //////////////////////////////////////////////////////////////////////////////
  // log control: a software write wins over the hardware clear of an enable

  wire logic next_rec_en  = wr_logctl ? reg_wdata[`IEL_LC_REC] :
                            (rec_en & ~(take_rec & ~capture_a));
  wire logic next_nrec_en = wr_logctl ? reg_wdata[`IEL_LC_NREC] :
                            (nrec_en & ~(take_nrec & ~capture_a));
  wire logic next_capture_a   = wr_logctl ? reg_wdata[`IEL_LC_CAPTURE_A] : capture_a;
  wire logic next_valid   = take_any | (wr_logctl ? reg_wdata[`IEL_LC_VALID] : valid);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_en  <= 1'b0;
      nrec_en <= 1'b0;
      capture_a   <= 1'b0;
      valid   <= 1'b0;
    end else begin
      rec_en  <= next_rec_en;
      nrec_en <= next_nrec_en;
      capture_a   <= next_capture_a;
      valid   <= next_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear; a new event wins over the clear

  logic [1:0]        ist;
  logic [1:0]        imask;
  iel_pkg::iel_sev_e last_sev;

  wire logic [1:0] ist_set    = {missed, take_any};
  wire logic [1:0] ist_clr    = wr_istat ? reg_wdata[1:0] : 2'h0;
  wire logic [1:0] next_ist   = ist_set | (ist & ~ist_clr);
  wire logic [1:0] next_imask = wr_imask ? reg_wdata[1:0] : imask;
  wire logic       next_irq   = |(next_ist & next_imask);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ist      <= 2'h0;
      imask    <= 2'h0;
      irq      <= 1'b0;
      last_sev <= iel_pkg::IEL_SEV_NONE;
    end else begin
      ist      <= next_ist;
      imask    <= next_imask;
      irq      <= next_irq;
      last_sev <= take_any ? cur_sev : last_sev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path: data only in the cycle after the strobe, unmapped reads zero

  wire logic [31:0] logctl_q = {valid, 15'h0, nrec_en, rec_en, 1'b0, capture_a, 12'h0};
  wire logic [31:0] istat_q  = {26'h0, last_sev, 2'h0, ist};
  wire logic [31:0] rd_sel   =
    (reg_addr == `IEL_OFF_MASK2)  ? {24'h0, mask2}  :
    (reg_addr == `IEL_OFF_MCMASK) ? {24'h0, mcmask} :
    (reg_addr == `IEL_OFF_LOG0)   ? log0            :
    (reg_addr == `IEL_OFF_LOG1)   ? log1            :
    (reg_addr == `IEL_OFF_LOG2)   ? log2            :
    (reg_addr == `IEL_OFF_LOG3)   ? log3            :
    (reg_addr == `IEL_OFF_LOGCTL) ? logctl_q        :
    (reg_addr == `IEL_OFF_ISTAT)  ? istat_q         :
    (reg_addr == `IEL_OFF_IMASK)  ? {30'h0, imask}  : 32'h0;
  wire logic [31:0] next_rd_data = reg_rd ? rd_sel : 32'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= next_rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_err2_route: assert property (
    |(err_flags & mask2) |=> error_out2)
    else $error("routed error did not raise error output 2");

  a_mc_route: assert property (
    |(err_flags & mcmask) |=> machine_check_output)
    else $error("routed error did not raise machine check");

  a_mask_write: assert property (
    wr_mcmask |=> mcmask == $past(reg_wdata[7:0]))
    else $error("machine check mask did not take the write");

  a_mask_next_cycle: assert property (
    (wr_mask2 && reg_wdata[7:0] == 8'h00) |=> ##1 !error_out2)
    else $error("cleared error-2 mask still routes");

  a_addr_log: assert property (
    take_any |=> log0 == {$past(txn_addr[31:2]), $past(txn_write), $past(txn_dram)})
    else $error("address log does not match the faulting access");

  a_attr_log: assert property (
    take_full |=> (log1[19:16] == $past(pending_writeback_count))
                  && (log1[14:8] == $past(directory_entry_id))
                  && !log1[15] && !log1[20])
    else $error("attribute log fields wrong");

  a_flag_log: assert property (
    take_full |=> log1[23:21] == {$past(line_status_flag), $past(non_posted_flag),
                                  $past(bypass_unused_flag)})
    else $error("attribute log flags wrong");

  a_tag_snap: assert property (
    take_full |=> (log2 == $past(request_tag_snapshot[31:0]))
                  && (log3 == $past(request_tag_snapshot[63:32])))
    else $error("tag snapshot not captured");

  a_enable_clear: assert property (
    (take_rec && !capture_a && !wr_logctl) |=> !rec_en ##1 (!rec_en || $past(wr_logctl)))
    else $error("recoverable enable not cleared after capture");

  a_no_capture_off: assert property (
    (!rec_en && !nrec_en && !wr_log2) |=> $stable(log2))
    else $error("capture while logging disabled");

  a_read_latency: assert property (
    (reg_rd && reg_addr == `IEL_OFF_LOG2) |=> reg_rdata == $past(log2))
    else $error("read data not the log value one cycle later");

  c_capture_rec: cover property (take_rec ##1 valid);
  c_capture_nrec: cover property (take_nrec && capture_a ##1 nrec_en);
  c_both_outputs: cover property (error_out2 && machine_check_output);
  c_irq_raised: cover property (missed ##1 ist[`IEL_IS_MISSED] ##1 irq);

endmodule : iel_error_route_log

`default_nettype wire

/* File: verilog/iel_sticky_reg.sv */
// Purpose: software writable register that hardware can load
// Assumes: hardware load and software write may coincide
// Notes:   hardware load wins so a capture is never lost
`timescale 1ns/1ps
`default_nettype none

module iel_sticky_reg #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         sw_we,
  input  wire logic [W-1:0] sw_d,
  input  wire logic         hw_we,
  input  wire logic [W-1:0] hw_d,
  output var  logic [W-1:0] q
);

  wire logic [W-1:0] next_q = hw_we ? hw_d : (sw_we ? sw_d : q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_hw_wins: assert property (@(posedge clk) disable iff (sys_rst)
    hw_we |=> q == $past(hw_d))
    else $error("hardware load did not take priority");

endmodule : iel_sticky_reg

`default_nettype wire
